// ===== design/dmba_map.svh
// register map, field positions and codes of the default-master bus arbiter
`ifndef DMBA_MAP_SVH
`define DMBA_MAP_SVH

`define DMBA_CTRL_ADDR 8'h00
`define DMBA_STAT_ADDR 8'h04
`define DMBA_CTRL_RESET 8'h00
`define DMBA_PARK_HI 1
`define DMBA_PARK_LO 0
`define DMBA_VIS_BIT 5
`define DMBA_REGARB_BIT 6
`define DMBA_EXTARB_BIT 7
`define DMBA_PARK_EXT 2'h0
`define DMBA_PARK_CORE 2'h1
`define DMBA_PARK_DMA 2'h2
`define DMBA_PARK_CUR 2'h3
`define DMBA_BWC_MAX 3'h0
`define DMBA_ONEHOT_EXT 3'h1
`define DMBA_ONEHOT_CORE 3'h2
`define DMBA_ONEHOT_DMA 3'h4
`define DMBA_INT_MASK 3'h6
`define DMBA_SYNC_IDLE 2'h3
`define DMBA_SYNC_LOW 2'h0

`endif

// ===== design/dmba_pkg.sv
// types shared by the default-master bus arbiter
package dmba_pkg;

    typedef enum logic [1:0] {
        DMBA_M_EXT,
        DMBA_M_CORE,
        DMBA_M_DMA
    } dmba_master_t;

    typedef enum logic [1:0] {
        DMBA_RX_IDLE,
        DMBA_RX_WAIT,
        DMBA_RX_SHOW
    } dmba_rx_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } dmba_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } dmba_apb_rsp_t;

    typedef struct packed {
        logic valid;
        logic from_dma;
        logic to_base;
        logic [31:0] data;
    } dmba_reg_req_t;

    typedef struct packed {
        logic bus_request_n;
        logic xta_n;
        logic xta_oe;
        logic addr_strobe_inhibit;
        logic cs_strobe_inhibit;
        logic [31:0] data;
        logic data_oe;
    } dmba_pins_t;

    typedef struct packed {
        logic [7:0] ctrl;
        dmba_master_t owner;
        logic [2:0] grant;
        dmba_rx_t rx;
        logic [1:0] bg_sync;
        logic [1:0] ext_req_sync;
        logic [1:0] xta_sync;
        logic stall;
        logic done;
        logic viol;
        dmba_pins_t pins;
        dmba_apb_rsp_t apb;
    } dmba_state_t;

endpackage : dmba_pkg

// ===== design/dmba_arbiter.sv
// default-master arbiter for external, core and dma masters with register-space bus control
//
// The register addresses and the APB register port were left to the implementer.
`include "dmba_map.svh"

module dmba_arbiter (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire dmba_pkg::dmba_apb_req_t i_apb,
    output dmba_pkg::dmba_apb_rsp_t o_apb,
    input wire logic i_ext_req,
    input wire logic i_core_req,
    input wire logic i_dma_req,
    input wire logic [2:0] i_dma_bandwidth_control,
    output logic [2:0] o_grant,
    input wire dmba_pkg::dmba_reg_req_t i_reg_req,
    output logic o_reg_done,
    output logic o_core_stall,
    input wire logic i_bus_grant_in_n,
    input wire logic i_external_transfer_ack_n,
    output dmba_pkg::dmba_pins_t o_pins
);
    import dmba_pkg::*;

    dmba_state_t q;
    dmba_state_t d;

    // one-hot grant pattern of a master
    function automatic logic [2:0] onehot(input dmba_master_t m);
        logic [2:0] r;
        r = `DMBA_ONEHOT_EXT;
        unique case (m)
            DMBA_M_EXT: r = `DMBA_ONEHOT_EXT;
            DMBA_M_CORE: r = `DMBA_ONEHOT_CORE;
            DMBA_M_DMA: r = `DMBA_ONEHOT_DMA;
            default: r = `DMBA_ONEHOT_EXT;
        endcase
        return r;
    endfunction : onehot

    // highest ranked requester under the parking code and dma bandwidth
    function automatic dmba_master_t pick(input logic [2:0] req, input logic [1:0] park,
                                          input logic bwc_max);
        dmba_master_t ord [3];
        dmba_master_t w;
        w = DMBA_M_EXT;
        unique case (park)
            `DMBA_PARK_CORE: begin
                ord = '{DMBA_M_CORE, DMBA_M_EXT, DMBA_M_DMA};
            end
            `DMBA_PARK_DMA: begin
                ord = '{DMBA_M_DMA, DMBA_M_EXT, DMBA_M_CORE};
            end
            default: begin
                // codes 00 and 11 share one ranking
                ord = '{DMBA_M_EXT, DMBA_M_CORE, DMBA_M_DMA};
            end
        endcase
        // core sits ahead of dma in every order but code 10, so swapping lifts dma
        if (bwc_max && park != `DMBA_PARK_DMA) begin
            for (int i = 0; i < 3; i++) begin
                if (ord[i] == DMBA_M_CORE) begin
                    ord[i] = DMBA_M_DMA;
                end else if (ord[i] == DMBA_M_DMA) begin
                    ord[i] = DMBA_M_CORE;
                end
            end
        end
        for (int i = 2; i >= 0; i--) begin
            if (|(req & onehot(ord[i]))) begin
                w = ord[i];
            end
        end
        return w;
    endfunction : pick

    logic [1:0] park;
    logic ext_en;
    logic reg_arb;
    logic vis;
    logic bwc_max;
    logic [2:0] req_eff;
    logic owner_ok;
    logic apb_hit;
    logic [7:0] status;
    dmba_master_t park_tgt;
    logic viol_set;

    // control fields decoded from the register, and the dma bandwidth decoded from its input pins
    assign park = q.ctrl[`DMBA_PARK_HI:`DMBA_PARK_LO];
    assign ext_en = q.ctrl[`DMBA_EXTARB_BIT];
    assign reg_arb = q.ctrl[`DMBA_REGARB_BIT];
    assign vis = q.ctrl[`DMBA_VIS_BIT];
    assign bwc_max = (i_dma_bandwidth_control == `DMBA_BWC_MAX);
    assign apb_hit = i_apb.psel && i_apb.penable && !q.apb.pready;
    assign status = {q.viol, q.xta_sync[1], q.bg_sync[1], q.rx == DMBA_RX_SHOW,
                     q.rx == DMBA_RX_WAIT, onehot(q.owner)};

    // requests that may compete; external ones only while admitted
    assign req_eff = {i_dma_req, i_core_req, q.ext_req_sync[1] & ext_en};
    assign owner_ok = |(req_eff & onehot(q.owner));

    // parked master, falling back to the internal ranking when externals are shut out
    always_comb begin
        park_tgt = DMBA_M_EXT;
        unique case (park)
            `DMBA_PARK_EXT: park_tgt = DMBA_M_EXT;
            `DMBA_PARK_CORE: park_tgt = DMBA_M_CORE;
            `DMBA_PARK_DMA: park_tgt = DMBA_M_DMA;
            default: park_tgt = q.owner;
        endcase
        if (park_tgt == DMBA_M_EXT && !ext_en) begin
            park_tgt = pick(`DMBA_INT_MASK, park, bwc_max);
        end
    end

    // whole next state of the block
    always_comb begin
        d = q;
        d.bg_sync = {q.bg_sync[0], i_bus_grant_in_n};
        d.ext_req_sync = {q.ext_req_sync[0], i_ext_req};
        d.xta_sync = {q.xta_sync[0], i_external_transfer_ack_n};
        d.done = 1'b0;
        viol_set = 1'b0;

        // ownership moves only once the owner drops its request, i.e. between transfers
        if (!owner_ok) begin
            if (|req_eff) begin
                d.owner = pick(req_eff, park, bwc_max);
            end else begin
                d.owner = park_tgt;
            end
        end
        d.grant = onehot(d.owner);

        // register-space transfer sequencer; valid is held until done, so skip a done cycle
        unique case (q.rx)
            DMBA_RX_IDLE: begin
                if (i_reg_req.valid && !q.done) begin
                    if (i_reg_req.to_base) begin
                        // base register is core-only and never leaves the chip
                        d.done = 1'b1;
                        if (i_reg_req.from_dma) begin
                            d.viol = 1'b1;
                            viol_set = 1'b1;
                        end
                    end else if (reg_arb) begin
                        d.rx = (q.bg_sync[1] == 1'b0) ? DMBA_RX_SHOW : DMBA_RX_WAIT;
                    end else begin
                        d.done = 1'b1;
                    end
                end
            end
            DMBA_RX_WAIT: begin
                // no timeout: an arbiter that never grants leaves the master blocked
                if (q.bg_sync[1] == 1'b0) begin
                    d.rx = DMBA_RX_SHOW;
                end
            end
            DMBA_RX_SHOW: begin
                d.rx = DMBA_RX_IDLE;
                d.done = 1'b1;
            end
            default: begin
                d.rx = DMBA_RX_IDLE;
            end
        endcase

        // pin and stall outputs follow the next sequencer state
        d.stall = (d.rx != DMBA_RX_IDLE) && !i_reg_req.from_dma;
        d.pins.bus_request_n = (d.rx == DMBA_RX_IDLE);
        d.pins.xta_oe = (d.rx == DMBA_RX_SHOW);
        d.pins.xta_n = (d.rx != DMBA_RX_SHOW);
        d.pins.addr_strobe_inhibit = (d.rx == DMBA_RX_SHOW);
        d.pins.cs_strobe_inhibit = (d.rx == DMBA_RX_SHOW);
        d.pins.data_oe = (d.rx == DMBA_RX_SHOW) && vis && reg_arb;
        d.pins.data = d.pins.data_oe ? i_reg_req.data : '0;

        // apb slave: one wait state, then a one-cycle pready
        d.apb.pready = apb_hit;
        d.apb.pslverr = 1'b0;
        d.apb.prdata = '0;
        if (apb_hit) begin
            if (i_apb.paddr == `DMBA_CTRL_ADDR) begin
                if (i_apb.pwrite) begin
                    d.ctrl = i_apb.pwdata[7:0];
                end else begin
                    d.apb.prdata = {24'h00_0000, q.ctrl};
                end
            end else if (i_apb.paddr == `DMBA_STAT_ADDR) begin
                if (!i_apb.pwrite) begin
                    d.apb.prdata = {24'h00_0000, status};
                    // read clears the violation flag; a violation landing in the same cycle wins
                    d.viol = viol_set;
                end
            end else begin
                d.apb.pslverr = 1'b1;
            end
        end
    end

    // single state register, synchronous active-low reset
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            q <= '0;
            q.ctrl <= `DMBA_CTRL_RESET;
            q.owner <= DMBA_M_EXT;
            q.grant <= `DMBA_ONEHOT_EXT;
            q.rx <= DMBA_RX_IDLE;
            q.bg_sync <= `DMBA_SYNC_IDLE;
            q.ext_req_sync <= `DMBA_SYNC_LOW;
            q.xta_sync <= `DMBA_SYNC_IDLE;
            q.pins.bus_request_n <= 1'b1;
            q.pins.xta_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // every output straight from the state register
    assign o_apb = q.apb;
    assign o_grant = q.grant;
    assign o_reg_done = q.done;
    assign o_core_stall = q.stall;
    assign o_pins = q.pins;

endmodule : dmba_arbiter

// ===== testbench/dmba_assertions.sv
// concurrent checks on the ports of the default-master bus arbiter
module dmba_chk (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire dmba_pkg::dmba_apb_req_t i_apb,
    input wire dmba_pkg::dmba_apb_rsp_t o_apb,
    input wire logic i_core_req,
    input wire logic i_dma_req,
    input wire logic [2:0] o_grant,
    input wire logic o_reg_done,
    input wire logic o_core_stall,
    input wire dmba_pkg::dmba_pins_t o_pins
);
    import dmba_pkg::*;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_resetn);
    // exactly one master owns the bus
    chk_grant_onehot: assert property ($onehot(o_grant))
        else $error("grant is not one-hot");
    chk_apb_answer: assert property (i_apb.psel && i_apb.penable && !o_apb.pready |=> o_apb.pready)
        else $error("register access not answered");
    // a core or dma owner that still requests is never cut off mid-transfer
    chk_core_hold: assert property (o_grant == 3'h2 && i_core_req |=> o_grant == 3'h2)
        else $error("core lost the bus mid-transfer");
    chk_dma_hold: assert property (o_grant == 3'h4 && i_dma_req |=> o_grant == 3'h4)
        else $error("dma lost the bus mid-transfer");
    chk_ack_driven: assert property (o_pins.xta_oe |-> !o_pins.xta_n)
        else $error("ack pin driven but not asserted");
    chk_strobes_off: assert property (o_pins.xta_oe |-> o_pins.addr_strobe_inhibit && o_pins.cs_strobe_inhibit)
        else $error("strobes not held off while shown");
    chk_data_shown: assert property (o_pins.data_oe |-> o_pins.xta_oe)
        else $error("data driven outside a shown transfer");
    chk_show_done: assert property (o_pins.xta_oe |=> !o_pins.xta_oe && o_reg_done)
        else $error("shown transfer did not end in one cycle");
    chk_stall_req: assert property (o_core_stall |-> !o_pins.bus_request_n)
        else $error("core stalled without asking for the bus");
    cover property (o_pins.data_oe);
    cover property (o_core_stall);
    cover property ($rose(o_grant[2]));
endmodule : dmba_chk

bind dmba_arbiter dmba_chk u_dmba_chk (.i_ref_clk, .i_resetn, .i_apb, .o_apb, .i_core_req, .i_dma_req,
    .o_grant, .o_reg_done, .o_core_stall, .o_pins);

// ===== testbench/dmba_ext_side.sv
// external bus arbitration model: grants the external bus and pulls up the ack pin
module dmba_ext_side (
    input wire logic i_ref_clk,
    input wire logic i_bus_request_n,
    input wire logic i_slow,
    input wire logic i_tied,
    input wire logic i_xta_n,
    input wire logic i_xta_oe,
    output logic o_bus_grant_n,
    output logic o_xta_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_q = 4'h0;
    initial o_bus_grant_n = 1'b1;
    // grant after a short or long wait; never withheld, so a waiting master always gets through
    always @(posedge i_ref_clk) begin
        if (i_tied) begin
            // single-master board: grant tied low, the device always owns the bus
            o_bus_grant_n <= 1'b0;
        end else if (i_bus_request_n) begin
            wait_q <= 4'h0;
            o_bus_grant_n <= 1'b1;
        end else if (wait_q == (i_slow ? 4'h6 : 4'h1)) begin
            o_bus_grant_n <= 1'b0;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
    // pull-up on the ack pin; the device wins only while it enables its driver
    assign o_xta_n = i_xta_oe ? i_xta_n : 1'b1;
endmodule : dmba_ext_side

// ===== testbench/default_master_bus_arbiter_bench.sv
// self-checking bench for the default-master bus arbiter
`include "dmba_map.svh"
module default_master_bus_arbiter_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import dmba_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic slow = 1'b0;
    logic tied = 1'b0;
    logic [2:0] rq = 3'h0;
    logic [2:0] bwc = 3'h1;
    dmba_apb_req_t apb = '0;
    dmba_reg_req_t rr = '0;
    dmba_apb_rsp_t apb_r;
    dmba_pins_t pins;
    logic [2:0] gnt;
    logic done, stall, bg_n, xta_n, err;
    logic [31:0] rd;
    logic [3:0] s;
    int num_errors = 0;
    int comparisons = 0;
    // owners in expected grant order, three one-hot bits each, for park codes 00, 01, 10 and 11
    logic [8:0] ord [4] = '{9'h054, 9'h08C, 9'h10A, 9'h10A};
    initial forever #25 clk = ~clk;
    dmba_arbiter u_dmba_arbiter (.i_ref_clk(clk), .i_resetn(rst_n), .i_apb(apb), .o_apb(apb_r), .i_ext_req(rq[0]),
        .i_core_req(rq[1]), .i_dma_req(rq[2]), .i_dma_bandwidth_control(bwc), .o_grant(gnt), .i_reg_req(rr),
        .o_reg_done(done), .o_core_stall(stall), .i_bus_grant_in_n(bg_n), .i_external_transfer_ack_n(xta_n),
        .o_pins(pins));
    dmba_ext_side u_dmba_ext_side (.i_ref_clk(clk), .i_bus_request_n(pins.bus_request_n), .i_slow(slow), .i_tied(tied),
        .i_xta_n(pins.xta_n), .i_xta_oe(pins.xta_oe), .o_bus_grant_n(bg_n), .o_xta_n(xta_n));
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic hang();
        num_errors++;
        $display("wrong value at %0t: no answer in time", $time);
        give_verdict();
    endtask : hang
    // one apb transfer; request held until pready is seen
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        apb <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        apb.penable <= 1'b1;
        n = 0;
        // pready is a one-cycle pulse: take it, and the data, at the rising edge that samples it
        do begin
            @(posedge clk);
            n++;
        end while (apb_r.pready !== 1'b1 && n < 20);
        if (apb_r.pready !== 1'b1) hang();
        rd = apb_r.prdata;
        err = apb_r.pslverr;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
    endtask : bus
    task automatic want(input logic [2:0] g);
        int n;
        for (n = 0; n < 16 && gnt !== g; n++) @(negedge clk);
        if (gnt !== g) hang();
        check(gnt, g);
    endtask : want
    // register transfer; o collects {stall, data shown, bus requested, ack driven}
    task automatic xfer(input logic dma, input logic base, input logic [31:0] d, output logic [3:0] o);
        int n;
        o = 4'h0;
        @(posedge clk);
        rr <= '{1'b1, dma, base, d};
        for (n = 0; n < 40 && done !== 1'b1; n++) begin
            @(negedge clk);
            o |= {stall, pins.data_oe && pins.data === d, !pins.bus_request_n, pins.xta_oe};
        end
        if (n == 40) hang();
        @(posedge clk);
        rr.valid <= 1'b0;
    endtask : xfer
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, `DMBA_CTRL_ADDR, 32'h0);
        check(rd, 32'h0000_0000);
        bus(1'b1, `DMBA_CTRL_ADDR, 32'hFFFF_FF5C);
        bus(1'b0, `DMBA_CTRL_ADDR, 32'h0);
        check(rd, 32'h0000_005C);
        bus(1'b0, 8'h10, 32'h0);
        check(err, 1'b1);
        // each park code: idle owner, then rank by dropping the winner
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, `DMBA_CTRL_ADDR, 32'h0000_0080 | c);
            rq <= 3'h0;
            want(c == 3 ? 3'h2 : ord[c][8:6]);
            @(posedge clk);
            rq <= ord[c][8:6];
            repeat (4) @(posedge clk);
            rq <= 3'h7;
            want(ord[c][8:6]);
            // let the external request clear its two-stage synchroniser before the owner drops
            repeat (3) @(posedge clk);
            rq <= rq & ~ord[c][8:6];
            want(ord[c][5:3]);
            @(posedge clk);
            rq <= rq & ~ord[c][5:3];
            want(ord[c][2:0]);
        end
        bus(1'b1, `DMBA_CTRL_ADDR, 32'h0000_0080);
        rq <= 3'h0;
        bwc <= `DMBA_BWC_MAX;
        want(3'h1);
        @(posedge clk);
        rq <= 3'h6;
        want(3'h4);
        bus(1'b1, `DMBA_CTRL_ADDR, 32'h0000_0002);
        rq <= 3'h1;
        bwc <= 3'h1;
        repeat (8) @(posedge clk);
        check(gnt, 3'h4);
        rq <= 3'h0;
        bus(1'b1, `DMBA_CTRL_ADDR, 32'h0000_0000);
        xfer(1'b0, 1'b0, 32'h1111_2222, s);
        check(s, 4'h0);
        bus(1'b1, `DMBA_CTRL_ADDR, 32'h0000_0060);
        xfer(1'b1, 1'b0, 32'hA5C3_0F1E, s);
        check(s, 4'h7);
        xfer(1'b0, 1'b1, 32'h3333_4444, s);
        check(s, 4'h0);
        bus(1'b1, `DMBA_CTRL_ADDR, 32'h0000_0040);
        slow <= 1'b1;
        xfer(1'b0, 1'b0, 32'h5A5A_0001, s);
        check(s, 4'hB);
        xfer(1'b1, 1'b1, 32'h0000_0007, s);
        check(s, 4'h0);
        bus(1'b0, `DMBA_STAT_ADDR, 32'h0);
        check(rd[7], 1'b1);
        bus(1'b0, `DMBA_STAT_ADDR, 32'h0);
        check(rd[7], 1'b0);
        // grant tied low: a shown transfer goes out at once, no wait state
        tied <= 1'b1;
        bus(1'b1, `DMBA_CTRL_ADDR, 32'h0000_0060);
        xfer(1'b0, 1'b0, 32'h0F0F_1234, s);
        check(s, 4'hF);
        give_verdict();
    end
endmodule : default_master_bus_arbiter_bench
